/* pkg/rti_defs.svh */
// Register indices, field positions, reset values and bus codes
`ifndef RTI_DEFS_SVH
`define RTI_DEFS_SVH
`define RTI_IDX_CFG      8'h30
`define RTI_IDX_SRC      8'h31
`define RTI_IDX_XH       8'h32
`define RTI_IDX_XL       8'h33
`define RTI_IDX_YH       8'h34
`define RTI_IDX_YL       8'h35
`define RTI_IDX_ZH       8'h36
`define RTI_IDX_ZL       8'h37
`define RTI_IDX_DUR      8'h38
`define RTI_IDX_IST      8'h3A
`define RTI_IDX_IMSK     8'h3B
`define RTI_CFG_ANDOR    7
`define RTI_CFG_LATCH    6
`define RTI_DUR_WAIT     7
`define RTI_IST_RISE     0
`define RTI_IST_FALL     1
`define RTI_RST_BYTE     8'h00
`define RTI_RST_HIGH     7'h00
`define RTI_RST_IRQ2     2'h0
`define RTI_RESP_OKAY    2'h0
`define RTI_RESP_SLVERR  2'h2
`endif

/* pkg/rti_pkg.sv */
// Types of the rate threshold interrupt timing block
package rti_pkg;
	typedef enum logic [0:0] {
		RTI_IDLE   = 1'b0,
		RTI_ACTIVE = 1'b1
	} rti_phase_t;

	typedef struct packed {
		logic [7:0] cfg;
		logic [6:0] xHi;
		logic [7:0] xLo;
		logic [6:0] yHi;
		logic [7:0] yLo;
		logic [6:0] zHi;
		logic [7:0] zLo;
		logic [7:0] dur;
		rti_phase_t phase;
		logic [6:0] count;
		logic       latched;
		logic [5:0] flags;
		logic [1:0] status;
		logic [1:0] mask;
		logic       awTaken;
		logic       wTaken;
		logic [7:0] awIdx;
		logic [7:0] wData;
		logic       wEn;
		logic       bvalid;
		logic [1:0] bresp;
		logic       rvalid;
		logic [1:0] rresp;
		logic [7:0] rdata;
	} rti_state_t;
endpackage

/* hdl/rti_core.sv */
// Threshold event timing, latch and source flags behind an AXI4-Lite slave
`timescale 1ns/100ps
`default_nettype none
`include "rti_defs.svh"

// Function
// - Y threshold low byte register, eight bits, resets to zero.
// - Z threshold high register: bit 7 unused, bits 6..0 threshold bits 14..8.
// - Z threshold low byte register, eight bits, resets to zero.
// - Duration register: wait enable bit 7, seven-bit count below, reset zero.
// - Event recognised only after condition persists for the duration count.
// - Duration is counted in output samples, so it scales with data rate.
// - Wait clear: interrupt drops as soon as signal crosses back.
// - Wait set: interrupt drops only after duration samples counted past crossing.
// - Per-axis high and low enables, event when rate above or below threshold.
// - Enabled events combined by OR when combination bit zero, AND when one.
// - Latched mode holds interrupt until source read; read clears and refreshes flags.
// - Read-only source register: active flag plus per-axis high and low flags.
module rti_core
	import rti_pkg::*;
#(
	parameter int ADDR_W = 12
) (
	input  wire logic              clk,
	input  wire logic              reset,
	input  wire logic              sampleStrobe,
	input  wire logic [15:0]       xRate,
	input  wire logic [15:0]       yRate,
	input  wire logic [15:0]       zRate,
	output logic                   firstEventOutput,
	output logic                   irqOut,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready
);

////////////////////////////////////////////////////////////////////////////////

	rti_state_t s;
	rti_state_t next_s;
	logic [15:0] rateAxis [3];
	logic [14:0] limitAxis [3];
	logic [5:0]  events;
	logic [5:0]  liveFlags;
	logic        condition;
	logic        rise;
	logic        fall;
	logic        srcRead;
	logic        doWrite;
	logic [7:0]  arIdx;

	assign rateAxis[0] = xRate;
	assign rateAxis[1] = yRate;
	assign rateAxis[2] = zRate;
	assign limitAxis[0] = {s.xHi, s.xLo};
	assign limitAxis[1] = {s.yHi, s.yLo};
	assign limitAxis[2] = {s.zHi, s.zLo};

	// Bit 2a is the low event, 2a+1 the high event, matching the enables
	for (genvar a = 0; a < 3; a++) begin : g_axis
		assign events[2*a+1] = $signed(rateAxis[a]) > $signed({1'b0, limitAxis[a]});
		assign events[2*a]   = $signed(rateAxis[a]) < $signed({1'b0, limitAxis[a]});
	end

	assign liveFlags = events & s.cfg[5:0];

	// With nothing enabled the AND form would be vacuously true; treat as no event
	always_comb begin
		if (s.cfg[`RTI_CFG_ANDOR]) begin
			condition = (s.cfg[5:0] != 6'h00) && ((events & s.cfg[5:0]) == s.cfg[5:0]);
		end else begin
			condition = |liveFlags;
		end
	end

	assign arIdx   = s_axi_araddr[9:2];
	assign srcRead = s_axi_arvalid && s_axi_arready && (arIdx == `RTI_IDX_SRC);
	assign doWrite = s.awTaken && s.wTaken;

////////////////////////////////////////////////////////////////////////////////

	function automatic logic [8:0] read_reg(input logic [7:0] idx, input rti_state_t st,
		input logic [5:0] live);
		logic       ia;
		logic [5:0] fl;
		ia = st.cfg[`RTI_CFG_LATCH] ? st.latched : (st.phase == RTI_ACTIVE);
		fl = st.cfg[`RTI_CFG_LATCH] ? st.flags : live;
		case (idx)
			`RTI_IDX_CFG:  read_reg = {1'b1, st.cfg};
			`RTI_IDX_SRC:  read_reg = {1'b1, 1'b0, ia, fl};
			`RTI_IDX_XH:   read_reg = {1'b1, 1'b0, st.xHi};
			`RTI_IDX_XL:   read_reg = {1'b1, st.xLo};
			`RTI_IDX_YH:   read_reg = {1'b1, 1'b0, st.yHi};
			`RTI_IDX_YL:   read_reg = {1'b1, st.yLo};
			`RTI_IDX_ZH:   read_reg = {1'b1, 1'b0, st.zHi};
			`RTI_IDX_ZL:   read_reg = {1'b1, st.zLo};
			`RTI_IDX_DUR:  read_reg = {1'b1, st.dur};
			`RTI_IDX_IST:  read_reg = {1'b1, 6'h00, st.status};
			`RTI_IDX_IMSK: read_reg = {1'b1, 6'h00, st.mask};
			default:       read_reg = 9'h000;
		endcase
	endfunction

////////////////////////////////////////////////////////////////////////////////

	always_comb begin
		logic [8:0] rd;
		logic [1:0] w1c;
		rd = 9'h000;
		w1c = 2'h0;
		next_s = s;
		rise = 1'b0;
		fall = 1'b0;

		// Event timing advances only on sample strobes
		if (sampleStrobe) begin
			if (s.phase == RTI_IDLE) begin
				if (!condition) begin
					next_s.count = 7'h00;
				end else if (s.count >= s.dur[6:0]) begin
					next_s.phase = RTI_ACTIVE;
					next_s.count = 7'h00;
					rise = 1'b1;
				end else begin
					next_s.count = s.count + 7'h01;
				end
			end else begin
				if (condition) begin
					next_s.count = 7'h00;
				end else if (!s.dur[`RTI_DUR_WAIT]) begin
					next_s.phase = RTI_IDLE;
					fall = 1'b1;
				end else if (s.count >= s.dur[6:0]) begin
					next_s.phase = RTI_IDLE;
					next_s.count = 7'h00;
					fall = 1'b1;
				end else begin
					next_s.count = s.count + 7'h01;
				end
			end
		end

		// Read clears and refreshes; a recognition in the same cycle wins
		if (srcRead) begin
			next_s.latched = 1'b0;
			next_s.flags = liveFlags;
		end
		// Only latch in latched mode, so switching modes cannot raise a stale line
		if (rise && s.cfg[`RTI_CFG_LATCH]) begin
			next_s.latched = 1'b1;
			next_s.flags = liveFlags;
		end

		// Write channel: address and data taken independently
		if (s_axi_awvalid && s_axi_awready) begin
			next_s.awTaken = 1'b1;
			next_s.awIdx = s_axi_awaddr[9:2];
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_s.wTaken = 1'b1;
			next_s.wData = s_axi_wdata[7:0];
			next_s.wEn = s_axi_wstrb[0];
		end
		if (s.bvalid && s_axi_bready) begin
			next_s.bvalid = 1'b0;
		end
		if (doWrite) begin
			next_s.awTaken = 1'b0;
			next_s.wTaken = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp = `RTI_RESP_OKAY;
			case (s.awIdx)
				`RTI_IDX_CFG:  if (s.wEn) next_s.cfg = s.wData;
				`RTI_IDX_XH:   if (s.wEn) next_s.xHi = s.wData[6:0];
				`RTI_IDX_XL:   if (s.wEn) next_s.xLo = s.wData;
				`RTI_IDX_YH:   if (s.wEn) next_s.yHi = s.wData[6:0];
				`RTI_IDX_YL:   if (s.wEn) next_s.yLo = s.wData;
				`RTI_IDX_ZH:   if (s.wEn) next_s.zHi = s.wData[6:0];
				`RTI_IDX_ZL:   if (s.wEn) next_s.zLo = s.wData;
				`RTI_IDX_DUR:  if (s.wEn) next_s.dur = s.wData;
				`RTI_IDX_IST:  if (s.wEn) w1c = s.wData[1:0];
				`RTI_IDX_IMSK: if (s.wEn) next_s.mask = s.wData[1:0];
				// Source register is read-only; a write is accepted and dropped
				`RTI_IDX_SRC:  w1c = 2'h0;
				default:       next_s.bresp = `RTI_RESP_SLVERR;
			endcase
		end

		// Sticky status, set beats write-one-to-clear
		next_s.status = (s.status & ~w1c) | {fall, rise};

		// Read channel
		if (s.rvalid && s_axi_rready) begin
			next_s.rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			rd = read_reg(arIdx, s, liveFlags);
			next_s.rvalid = 1'b1;
			next_s.rdata = rd[7:0];
			next_s.rresp = rd[8] ? `RTI_RESP_OKAY : `RTI_RESP_SLVERR;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			s <= '{cfg: `RTI_RST_BYTE, xHi: `RTI_RST_HIGH, xLo: `RTI_RST_BYTE,
				yHi: `RTI_RST_HIGH, yLo: `RTI_RST_BYTE, zHi: `RTI_RST_HIGH,
				zLo: `RTI_RST_BYTE, dur: `RTI_RST_BYTE, phase: RTI_IDLE,
				count: `RTI_RST_HIGH, latched: 1'b0, flags: 6'h00,
				status: `RTI_RST_IRQ2, mask: `RTI_RST_IRQ2, awTaken: 1'b0,
				wTaken: 1'b0, awIdx: 8'h00, wData: 8'h00, wEn: 1'b0, bvalid: 1'b0,
				bresp: 2'h0, rvalid: 1'b0, rresp: 2'h0, rdata: 8'h00};
		end else begin
			s <= next_s;
		end
	end

////////////////////////////////////////////////////////////////////////////////

	// Outputs decode registered state only
	assign firstEventOutput = s.cfg[`RTI_CFG_LATCH] ? s.latched : (s.phase == RTI_ACTIVE);
	assign irqOut        = |(s.status & s.mask);
	assign s_axi_awready = !s.awTaken && !s.bvalid;
	assign s_axi_wready  = !s.wTaken && !s.bvalid;
	assign s_axi_bvalid  = s.bvalid;
	assign s_axi_bresp   = s.bresp;
	assign s_axi_arready = !s.rvalid;
	assign s_axi_rvalid  = s.rvalid;
	assign s_axi_rresp   = s.rresp;
	assign s_axi_rdata   = {24'h000000, s.rdata};

////////////////////////////////////////////////////////////////////////////////

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	logic regWrite;
	assign regWrite = doWrite && s.wEn;

	a_ylow_write: assert property (regWrite && s.awIdx == `RTI_IDX_YL
		|=> s.yLo == $past(s.wData)) else $error("Y low threshold not written");
	a_zhigh_write: assert property (regWrite && s.awIdx == `RTI_IDX_ZH
		|=> s.zHi == $past(s.wData[6:0])) else $error("Z high threshold not written");
	a_zlow_write: assert property (regWrite && s.awIdx == `RTI_IDX_ZL
		|=> s.zLo == $past(s.wData)) else $error("Z low threshold not written");
	a_dur_write: assert property (regWrite && s.awIdx == `RTI_IDX_DUR
		|=> s.dur == $past(s.wData) && s_axi_bvalid) else $error("Duration not written");
	a_no_early_event: assert property (s.phase == RTI_IDLE && sampleStrobe
		&& s.count < s.dur[6:0] |=> s.phase == RTI_IDLE) else $error("Event recognised early");
	a_hold_off_strobe: assert property (!sampleStrobe
		|=> $stable(s.phase) && $stable(s.count)) else $error("Timing moved without sample");
	a_fall_no_wait: assert property (s.phase == RTI_ACTIVE && sampleStrobe && !condition
		&& !s.dur[`RTI_DUR_WAIT] |=> s.phase == RTI_IDLE) else $error("No immediate fall");
	a_fall_wait: assert property (s.phase == RTI_ACTIVE && sampleStrobe && !condition
		&& s.dur[`RTI_DUR_WAIT] && s.count < s.dur[6:0] |=> s.phase == RTI_ACTIVE)
		else $error("Fell before wait count");
	a_latch_clear: assert property (s.cfg[`RTI_CFG_LATCH] && srcRead && !rise
		|=> !firstEventOutput) else $error("Latched output not cleared by read");
	a_latch_hold: assert property (s.cfg[`RTI_CFG_LATCH] && s.latched && !srcRead
		|=> s.latched) else $error("Latched output dropped without read");

	c_event_rise: cover property (s.phase == RTI_IDLE ##1 s.phase == RTI_ACTIVE);
	c_wait_fall: cover property (s.dur[`RTI_DUR_WAIT] && fall);
	c_latch_read: cover property (s.latched && srcRead);

endmodule // rti_core

`default_nettype wire

/* verification/rti_rate_source.sv */
// Sample clock source that stands in for the sensor data path
`timescale 1ns/100ps
`default_nettype none
module rti_rate_source #(
	parameter int PERIOD = 6
) (
	input  wire logic clk,
	input  wire logic reset,
	output logic      sampleStrobe
);
	logic [7:0] tick;

	// One-cycle tick per output sample; duration counts only these
	always_ff @(posedge clk) begin
		if (reset) begin
			tick <= 8'h00;
			sampleStrobe <= 1'b0;
		end else begin
			sampleStrobe <= (tick == 8'(PERIOD - 1));
			tick <= (tick == 8'(PERIOD - 1)) ? 8'h00 : tick + 8'h01;
		end
	end
endmodule // rti_rate_source
`default_nettype wire

/* verification/rate_threshold_interrupt_timing_tb.sv */
// Self-checking bench for the rate threshold interrupt timing block
`timescale 1ns/100ps
`default_nettype none
`include "rti_defs.svh"
module rate_threshold_interrupt_timing_tb;
	logic        clk = 1'b0;
	logic        reset = 1'b1;
	logic        sampleStrobe, firstEventOutput, irqOut;
	logic [15:0] yRate = 16'h0000;
	logic [15:0] zRate = 16'h0000;
	logic [11:0] awaddr = 12'h000;
	logic [11:0] araddr = 12'h000;
	logic [31:0] wdata = 32'h0000_0000;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	int          mismatches = 0;
	int          samplesChecked = 0;
	int          cycles = 0;

	always #25 clk = ~clk;

	rti_rate_source #(.PERIOD(6)) partner (.clk(clk), .reset(reset), .sampleStrobe(sampleStrobe));

	rti_core DUT (
		.clk(clk), .reset(reset), .sampleStrobe(sampleStrobe),
		.xRate(16'h0000), .yRate(yRate), .zRate(zRate),
		.firstEventOutput(firstEventOutput), .irqOut(irqOut),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready)
	);

	////////////////////////////////////////////////////////////////////////////////
	task automatic complete_run;
		$display("mismatches %0d compares %0d", mismatches, samplesChecked);
		if (mismatches == 0 && samplesChecked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samplesChecked++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// Address and data offered together, each dropped once taken
	task automatic wr(input logic [7:0] idx, input logic [31:0] d);
		@(posedge clk);
		awaddr <= {2'b00, idx, 2'b00};
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
		chk(32'(bresp), 32'(`RTI_RESP_OKAY));
	endtask

	task automatic rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		araddr <= {2'b00, idx, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask

	task automatic rchk(input logic [7:0] idx, input logic [31:0] exp);
		logic [31:0] d;
		logic [1:0]  r;
		rd(idx, d, r);
		chk(d, exp);
		chk(32'(r), 32'(`RTI_RESP_OKAY));
	endtask

	task automatic rates(input logic [15:0] y, input logic [15:0] z);
		@(posedge clk);
		yRate <= y;
		zRate <= z;
	endtask

	// Counts sample ticks, not clocks, then settles before looking
	task automatic step(input int n);
		repeat (n) begin
			do @(posedge clk); while (!sampleStrobe);
		end
		@(negedge clk);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			mismatches++;
			complete_run();
		end
	end

	initial begin
		logic [31:0] d;
		logic [1:0]  r;
		repeat (8) @(posedge clk);
		reset <= 1'b0;
		rchk(`RTI_IDX_YL, 32'h0000_0000);
		rchk(`RTI_IDX_ZH, 32'h0000_0000);
		rchk(`RTI_IDX_ZL, 32'h0000_0000);
		rchk(`RTI_IDX_DUR, 32'h0000_0000);
		wr(`RTI_IDX_YL, 32'hFFFF_FFA5);
		rchk(`RTI_IDX_YL, 32'h0000_00A5);
		wr(`RTI_IDX_ZH, 32'h0000_00FF);
		rchk(`RTI_IDX_ZH, 32'h0000_007F);
		wr(`RTI_IDX_ZL, 32'h0000_0080);
		rchk(`RTI_IDX_ZL, 32'h0000_0080);
		wr(`RTI_IDX_ZH, 32'h0000_0001);
		wr(`RTI_IDX_DUR, 32'h0000_0002);
		rchk(`RTI_IDX_DUR, 32'h0000_0002);
		rd(8'h00, d, r);
		chk(d, 32'h0000_0000);
		chk(32'(r), 32'(`RTI_RESP_SLVERR));
		wr(`RTI_IDX_IMSK, 32'h0000_0001);
		wr(`RTI_IDX_CFG, 32'h0000_0020);
		// Threshold 0x180 exactly is not above it
		rates(16'h0000, 16'h0180);
		step(3);
		chk(32'(firstEventOutput), 32'h0);
		rates(16'h0000, 16'h0181);
		step(2);
		chk(32'(firstEventOutput), 32'h0);
		step(1);
		chk(32'(firstEventOutput), 32'h1);
		chk(32'(irqOut), 32'h1);
		rates(16'h0000, 16'h0000);
		step(1);
		chk(32'(firstEventOutput), 32'h0);
		rchk(`RTI_IDX_IST, 32'h0000_0003);
		wr(`RTI_IDX_IST, 32'h0000_0003);
		@(negedge clk);
		chk(32'(irqOut), 32'h0);
		wr(`RTI_IDX_IMSK, 32'h0000_0000);
		wr(`RTI_IDX_DUR, 32'h0000_0082);
		rates(16'h0000, 16'h0181);
		step(3);
		chk(32'(firstEventOutput), 32'h1);
		chk(32'(irqOut), 32'h0);
		rates(16'h0000, 16'h0000);
		step(2);
		chk(32'(firstEventOutput), 32'h1);
		step(1);
		chk(32'(firstEventOutput), 32'h0);
		wr(`RTI_IDX_CFG, 32'h0000_00A4);
		wr(`RTI_IDX_DUR, 32'h0000_0000);
		rates(16'hFFFB, 16'h0000);
		step(2);
		chk(32'(firstEventOutput), 32'h0);
		rates(16'hFFFB, 16'h0181);
		step(1);
		chk(32'(firstEventOutput), 32'h1);
		wr(`RTI_IDX_CFG, 32'h0000_0024);
		rates(16'hFFFB, 16'h0000);
		step(1);
		chk(32'(firstEventOutput), 32'h1);
		rates(16'h03E8, 16'h0000);
		step(1);
		chk(32'(firstEventOutput), 32'h0);
		wr(`RTI_IDX_CFG, 32'h0000_0064);
		chk(32'(firstEventOutput), 32'h0);
		rates(16'hFFFB, 16'h0000);
		step(1);
		chk(32'(firstEventOutput), 32'h1);
		rates(16'h03E8, 16'h0000);
		step(2);
		chk(32'(firstEventOutput), 32'h1);
		rchk(`RTI_IDX_SRC, 32'h0000_0044);
		repeat (2) @(negedge clk);
		chk(32'(firstEventOutput), 32'h0);
		complete_run();
	end
endmodule // rate_threshold_interrupt_timing_tb
`default_nettype wire
